// *** hw/vscale_consts.vh ***
`ifndef VSCALE_CONSTS_VH
`define VSCALE_CONSTS_VH
// Clock rate and I2C timing
`define REF_CLK_HZ 50000000
`define I2C_FS_HZ 400000
`define I2C_QTR_DIV ((`REF_CLK_HZ + 4 * `I2C_FS_HZ - 1) / (4 * `I2C_FS_HZ))
`define SLOW_DIV (`REF_CLK_HZ / 32768)
// Processor rail operating points, index 0 = lowest
`define PROC_OPP_COUNT 5
`define PROC_OPP_LOW 3'h0
`define PROC_OPP_HIGH 3'h4
// Processor clock ceilings in MHz per point
`define PROC_MHZ_0 10'h07D
`define PROC_MHZ_1 10'h0FA
`define PROC_MHZ_2 10'h1F4
`define PROC_MHZ_3 10'h226
`define PROC_MHZ_4 10'h258
// Regulator voltage codes, 0.8 V base in 25 mV steps
`define VCODE_0 6'h06
`define VCODE_1 6'h08
`define VCODE_2 6'h10
`define VCODE_3 6'h13
`define VCODE_4 6'h16
// Interconnect points: ceilings in tenths of MHz
`define ICON_OPP_HIGH 2'h2
`define ICON_CLK_0 11'h19F
`define ICON_CLK_1 11'h3E8
`define ICON_CLK_2 11'h67C
// Regulator register addresses and values
`define PMIC_REG_TARGET 8'h06
`define PMIC_REG_CTRL 8'h04
`define PMIC_REG_GO 8'h07
`define PMIC_GO_VAL 8'h80
`define PMIC_CTRL_OFF 8'h08
`define PMIC_CTRL_ON 8'h0F
`define PMIC_ADDR 7'h48
`define PMIC_CTRL_ALL_OFF 8'h00
// Bit slots of the three acknowledges in one frame
`define I2C_ACK_ADDR 5'h08
`define I2C_ACK_REG 5'h11
`define I2C_ACK_DATA 5'h1A
`endif

// *** hw/i2c_writer.v ***
`timescale 1ns/1ps
`include "vscale_consts.vh"
// Single-byte register write master for full-speed I2C
module i2c_writer #(
  parameter QTR = `I2C_QTR_DIV
) (
  input wire clk,
  input wire rstn,
  input wire start,
  input wire [6:0] dev_addr,
  input wire [7:0] reg_addr,
  input wire [7:0] data,
  input wire sda_in,
  output reg scl_oe_ff,
  output reg sda_oe_ff,
  output reg busy_ff,
  output reg done_ff,
  output reg nack_ff
);
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_BIT = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_END = 3'h4;
  reg [2:0] state_ff;
  reg [15:0] cnt_ff;
  reg [1:0] ph_ff;
  reg [26:0] sh_ff;
  reg [4:0] bit_ff;
  wire tick = (cnt_ff == QTR - 1);
  wire ack_slot = (bit_ff == `I2C_ACK_ADDR) || (bit_ff == `I2C_ACK_REG) ||
                  (bit_ff == `I2C_ACK_DATA);
  // Frame sequencer; open-drain so enable low releases the line
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 16'h0000;
      ph_ff <= 2'h0;
      sh_ff <= 27'h0000000;
      bit_ff <= 5'h00;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      cnt_ff <= tick ? 16'h0000 : cnt_ff + 16'h0001;
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= 16'h0000;
          if (start) begin
            sh_ff <= {dev_addr, 1'b0, 1'b1, reg_addr, 1'b1, data, 1'b1};
            bit_ff <= 5'h00;
            ph_ff <= 2'h0;
            busy_ff <= 1'b1;
            nack_ff <= 1'b0;
            state_ff <= ST_START;
          end
        end
        ST_START: if (tick) begin
          ph_ff <= ph_ff + 2'h1;
          if (ph_ff == 2'h1) sda_oe_ff <= 1'b1;
          if (ph_ff == 2'h3) begin
            scl_oe_ff <= 1'b1;
            state_ff <= ST_BIT;
          end
        end
        ST_BIT: if (tick) begin
          ph_ff <= ph_ff + 2'h1;
          case (ph_ff)
            2'h0: sda_oe_ff <= ~sh_ff[26];
            2'h1: scl_oe_ff <= 1'b0;
            2'h2: if (ack_slot && sda_in) nack_ff <= 1'b1;
            default: begin
              scl_oe_ff <= 1'b1;
              sh_ff <= {sh_ff[25:0], 1'b1};
              bit_ff <= bit_ff + 5'h01;
              if (bit_ff == `I2C_ACK_DATA) state_ff <= ST_STOP;
            end
          endcase
        end
        ST_STOP: if (tick) begin
          ph_ff <= ph_ff + 2'h1;
          if (ph_ff == 2'h0) sda_oe_ff <= 1'b1;
          if (ph_ff == 2'h1) scl_oe_ff <= 1'b0;
          if (ph_ff == 2'h3) begin
            sda_oe_ff <= 1'b0;
            state_ff <= ST_END;
          end
        end
        ST_END: begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** hw/voltage_scaling_standby_ctrl.v ***
// Overview of operation
// - Five processor points; processor clock never above current ceiling.
// - Three interconnect points with 41.5, 100, 166 MHz ceilings.
// - Lower a rail voltage only after its clock is reduced.
// - Interconnect fixed at 1.15 V; no voltage commands for it.
// - Processor voltage change needs target write then go write.
// - No closed-loop single-write adjustment; software-driven only.
// - Monitor flags need; host software requests voltage change.
// - Clock request output drops in retention or off when enabled.
// - Off-mode output tells regulators they may shut down, only when I2C sequencing is disabled.
// - Wake domain runs on 32 kHz tick watching wake events.
// - Optionally sequence rails off and on by I2C commands.
// - Sleep entry lowers processor rail to lowest point by two writes.
// - Off entry disables processor converter with one control write.
// - Off entry disables interconnect converter with one control write.
// - Full-speed I2C link; only processor converter adjustable.
`timescale 1ns/1ps
`include "vscale_consts.vh"
module voltage_scaling_standby_ctrl #(
  parameter QTR = `I2C_QTR_DIV,
  parameter SLOW_DIV = `SLOW_DIV
) (
  input wire REF_CLK,
  input wire RSTN,
  input wire OPP_REQ_VALID,
  input wire [2:0] OPP_REQ,
  input wire [9:0] PROC_CLK_REQ_MHZ,
  input wire [10:0] ICON_CLK_REQ,
  input wire MONITOR_NEED,
  input wire SLEEP_REQ,
  input wire RETENTION_REQ,
  input wire OFF_REQ,
  input wire WAKE_EVENT,
  input wire CLKREQ_AUTO_EN,
  input wire I2C_SEQ_EN,
  input wire SDA_IN,
  output reg SCL_OUT,
  output reg SCL_OE,
  output reg SDA_OUT,
  output reg SDA_OE,
  output reg [9:0] PROC_CLK_MHZ,
  output reg [10:0] ICON_CLK,
  output reg [2:0] OPP_CUR,
  output reg BUSY,
  output reg NACK,
  output reg ADJUST_NEEDED,
  output reg CLK_REQ,
  output reg OFF_MODE,
  output reg IN_OFF,
  output reg WAKE_SEEN
);
  // Sequencer states
  localparam ST_IDLE = 4'h0;
  localparam ST_TGT = 4'h1;
  localparam ST_GO = 4'h2;
  localparam ST_RAISE = 4'h3;
  localparam ST_OFF1 = 4'h4;
  localparam ST_OFF2 = 4'h5;
  localparam ST_OFF = 4'h6;
  localparam ST_ON1 = 4'h7;
  localparam ST_ON2 = 4'h8;
  localparam ST_WAIT = 4'h9;
  // Sequencer, command and synchroniser registers
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [3:0] ret_ff;
  reg [2:0] tgt_ff;
  reg [9:0] pclk_ff;
  reg [10:0] iclk_ff;
  reg cmd_ff;
  reg [7:0] creg_ff;
  reg [7:0] cdat_ff;
  reg sda_s1_ff;
  reg sda_s2_ff;
  reg wake_s1_ff;
  reg wake_s2_ff;
  reg mon_s1_ff;
  reg mon_s2_ff;
  reg [15:0] slow_cnt_ff;
  reg slow_tick_ff;
  wire w_scl_oe;
  wire w_sda_oe;
  wire w_busy;
  wire w_done;
  wire w_nack;
  // Lookup results
  reg [9:0] ceil_mhz;
  reg [5:0] vcode_tgt;
  reg [9:0] ceil_tgt;
  reg [10:0] iceil;
  // Per-point processor ceiling and voltage code lookup
  always @* begin
    ceil_mhz = `PROC_MHZ_0;
    ceil_tgt = `PROC_MHZ_0;
    vcode_tgt = `VCODE_0;
    case (OPP_CUR)
      3'h0: ceil_mhz = `PROC_MHZ_0;
      3'h1: ceil_mhz = `PROC_MHZ_1;
      3'h2: ceil_mhz = `PROC_MHZ_2;
      3'h3: ceil_mhz = `PROC_MHZ_3;
      default: ceil_mhz = `PROC_MHZ_4;
    endcase
    case (tgt_ff)
      3'h0: begin ceil_tgt = `PROC_MHZ_0; vcode_tgt = `VCODE_0; end
      3'h1: begin ceil_tgt = `PROC_MHZ_1; vcode_tgt = `VCODE_1; end
      3'h2: begin ceil_tgt = `PROC_MHZ_2; vcode_tgt = `VCODE_2; end
      3'h3: begin ceil_tgt = `PROC_MHZ_3; vcode_tgt = `VCODE_3; end
      default: begin ceil_tgt = `PROC_MHZ_4; vcode_tgt = `VCODE_4; end
    endcase
    // Interconnect always at top point since its rail is fixed
    case (`ICON_OPP_HIGH)
      2'h0: iceil = `ICON_CLK_0;
      2'h1: iceil = `ICON_CLK_1;
      default: iceil = `ICON_CLK_2;
    endcase
  end
  // Pin synchronisers
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
      mon_s1_ff <= 1'b0;
      mon_s2_ff <= 1'b0;
    end else begin
      sda_s1_ff <= SDA_IN;
      sda_s2_ff <= sda_s1_ff;
      wake_s1_ff <= WAKE_EVENT;
      wake_s2_ff <= wake_s1_ff;
      mon_s1_ff <= MONITOR_NEED;
      mon_s2_ff <= mon_s1_ff;
    end
  end
  // 32 kHz enable for the wake-up domain
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      slow_cnt_ff <= 16'h0000;
      slow_tick_ff <= 1'b0;
    end else begin
      slow_tick_ff <= (slow_cnt_ff == SLOW_DIV - 1);
      if (slow_cnt_ff == SLOW_DIV - 1)
        slow_cnt_ff <= 16'h0000;
      else
        slow_cnt_ff <= slow_cnt_ff + 16'h0001;
    end
  end
  // Write engine toward the regulator IC
  i2c_writer #(.QTR(QTR)) u_i2c (
    .clk(REF_CLK),
    .rstn(RSTN),
    .start(cmd_ff),
    .dev_addr(`PMIC_ADDR),
    .reg_addr(creg_ff),
    .data(cdat_ff),
    .sda_in(sda_s2_ff),
    .scl_oe_ff(w_scl_oe),
    .sda_oe_ff(w_sda_oe),
    .busy_ff(w_busy),
    .done_ff(w_done),
    .nack_ff(w_nack)
  );
  // Sequencer next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        // Off beats sleep, sleep beats a point request
        if (OFF_REQ && I2C_SEQ_EN)
          nxt_state = ST_OFF1;
        else if (OFF_REQ)
          nxt_state = ST_OFF;
        else if (SLEEP_REQ && OPP_CUR != `PROC_OPP_LOW)
          nxt_state = ST_TGT;
        else if (OPP_REQ_VALID && OPP_REQ != OPP_CUR &&
                 OPP_REQ <= `PROC_OPP_HIGH)
          nxt_state = ST_TGT;
      end
      ST_TGT: nxt_state = ST_WAIT;
      ST_GO: nxt_state = ST_WAIT;
      ST_OFF1: nxt_state = ST_WAIT;
      ST_OFF2: nxt_state = ST_WAIT;
      ST_ON1: nxt_state = ST_WAIT;
      ST_ON2: nxt_state = ST_WAIT;
      ST_WAIT: if (w_done) nxt_state = ret_ff;
      ST_RAISE: nxt_state = ST_IDLE;
      ST_OFF: if (WAKE_SEEN)
        nxt_state = I2C_SEQ_EN ? ST_ON1 : ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end
  // Sequencer registers and command issue
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= ST_IDLE;
      ret_ff <= ST_IDLE;
      tgt_ff <= `PROC_OPP_LOW;
      OPP_CUR <= `PROC_OPP_LOW;
      pclk_ff <= `PROC_MHZ_0;
      iclk_ff <= `ICON_CLK_2;
      cmd_ff <= 1'b0;
      creg_ff <= 8'h00;
      cdat_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (!OFF_REQ && SLEEP_REQ && OPP_CUR != `PROC_OPP_LOW) begin
            tgt_ff <= `PROC_OPP_LOW;
          end else if (!OFF_REQ && OPP_REQ_VALID)
            tgt_ff <= OPP_REQ;
        end
        ST_TGT: begin
          // Clock cut to new ceiling before any voltage drop
          if (tgt_ff < OPP_CUR && pclk_ff > ceil_tgt)
            pclk_ff <= ceil_tgt;
          creg_ff <= `PMIC_REG_TARGET;
          cdat_ff <= {2'h0, vcode_tgt};
          cmd_ff <= 1'b1;
          ret_ff <= ST_GO;
        end
        ST_GO: begin
          creg_ff <= `PMIC_REG_GO;
          cdat_ff <= `PMIC_GO_VAL;
          cmd_ff <= 1'b1;
          ret_ff <= ST_RAISE;
        end
        ST_RAISE: begin
          OPP_CUR <= tgt_ff;
        end
        ST_OFF1: begin
          creg_ff <= `PMIC_REG_CTRL;
          cdat_ff <= `PMIC_CTRL_OFF;
          cmd_ff <= 1'b1;
          ret_ff <= ST_OFF2;
        end
        ST_OFF2: begin
          creg_ff <= `PMIC_REG_CTRL;
          cdat_ff <= `PMIC_CTRL_ALL_OFF;
          cmd_ff <= 1'b1;
          ret_ff <= ST_OFF;
        end
        ST_ON1: begin
          creg_ff <= `PMIC_REG_CTRL;
          cdat_ff <= `PMIC_CTRL_ON;
          cmd_ff <= 1'b1;
          ret_ff <= ST_ON2;
        end
        ST_ON2: begin
          creg_ff <= `PMIC_REG_CTRL;
          cdat_ff <= `PMIC_CTRL_ON;
          cmd_ff <= 1'b1;
          ret_ff <= ST_IDLE;
        end
        default: ;
      endcase
      // Track requested clocks, clamped to the applied point's ceiling
      if (state_ff == ST_IDLE || state_ff == ST_OFF)
        pclk_ff <= (PROC_CLK_REQ_MHZ > ceil_mhz) ?
                   ceil_mhz : PROC_CLK_REQ_MHZ;
      iclk_ff <= (ICON_CLK_REQ > iceil) ? iceil : ICON_CLK_REQ;
    end
  end
  // Outputs, status and wake-up watch
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SCL_OUT <= 1'b0;
      SCL_OE <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      PROC_CLK_MHZ <= `PROC_MHZ_0;
      ICON_CLK <= `ICON_CLK_2;
      BUSY <= 1'b0;
      NACK <= 1'b0;
      ADJUST_NEEDED <= 1'b0;
      CLK_REQ <= 1'b1;
      OFF_MODE <= 1'b0;
      IN_OFF <= 1'b0;
      WAKE_SEEN <= 1'b0;
    end else begin
      SCL_OE <= w_scl_oe;
      SDA_OE <= w_sda_oe;
      // Never exceed the lower of old and new ceilings
      PROC_CLK_MHZ <= (pclk_ff > ceil_mhz) ? ceil_mhz : pclk_ff;
      ICON_CLK <= iclk_ff;
      // Status flags follow the sequencer state, write engine, monitor and retention inputs
      BUSY <= ((state_ff != ST_IDLE) && (state_ff != ST_OFF)) ||
              w_busy;
      if (w_done) NACK <= w_nack;
      ADJUST_NEEDED <= mon_s2_ff;
      IN_OFF <= (state_ff == ST_OFF);
      OFF_MODE <= (state_ff == ST_OFF) && !I2C_SEQ_EN;
      CLK_REQ <= !(CLKREQ_AUTO_EN &&
                   (RETENTION_REQ || state_ff == ST_OFF));
      // Wake watch runs only while off
      if (state_ff != ST_OFF)
        WAKE_SEEN <= 1'b0;
      else if (slow_tick_ff && wake_s2_ff)
        WAKE_SEEN <= 1'b1;
    end
  end
endmodule

// *** test/vscale_props.sv ***
`timescale 1ns/1ps
`include "vscale_consts.vh"
// Port checks of the voltage scaling controller
module vscale_props #(
  parameter QTR = `I2C_QTR_DIV
) (
  input wire REF_CLK,
  input wire RSTN,
  input wire MONITOR_NEED,
  input wire CLKREQ_AUTO_EN,
  input wire I2C_SEQ_EN,
  input wire SCL_OE,
  input wire [9:0] PROC_CLK_MHZ,
  input wire [10:0] ICON_CLK,
  input wire [2:0] OPP_CUR,
  input wire BUSY,
  input wire ADJUST_NEEDED,
  input wire CLK_REQ,
  input wire OFF_MODE,
  input wire IN_OFF
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // Processor clock ceiling per point
  function automatic [9:0] ceil_of(input [2:0] p);
    case (p)
      3'h0: ceil_of = `PROC_MHZ_0;
      3'h1: ceil_of = `PROC_MHZ_1;
      3'h2: ceil_of = `PROC_MHZ_2;
      3'h3: ceil_of = `PROC_MHZ_3;
      default: ceil_of = `PROC_MHZ_4;
    endcase
  endfunction
  // Length of the present clock-low phase
  reg [15:0] low_cnt_ff;
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN)
      low_cnt_ff <= 16'h0000;
    else if (SCL_OE)
      low_cnt_ff <= low_cnt_ff + 16'h0001;
    else
      low_cnt_ff <= 16'h0000;
  end
  property p_clk_ceiling;
    OPP_CUR <= `PROC_OPP_HIGH && PROC_CLK_MHZ <= ceil_of(OPP_CUR);
  endproperty
  a_clk_ceiling: assert property (p_clk_ceiling)
    else $error("processor clock above ceiling");
  property p_icon_ceiling;
    ICON_CLK <= `ICON_CLK_2;
  endproperty
  a_icon_ceiling: assert property (p_icon_ceiling)
    else $error("interconnect clock above ceiling");
  property p_lower_after_clk;
    OPP_CUR < $past(OPP_CUR) |-> $past(PROC_CLK_MHZ) <= ceil_of(OPP_CUR);
  endproperty
  a_lower_after_clk: assert property (p_lower_after_clk)
    else $error("point lowered before clock");
  property p_opp_needs_seq;
    $changed(OPP_CUR) |-> $past(BUSY);
  endproperty
  a_opp_needs_seq: assert property (p_opp_needs_seq)
    else $error("point changed without write sequence");
  property p_scl_low;
    low_cnt_ff <= 8 * QTR;
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too long");
  property p_clkreq_off;
    $rose(IN_OFF) && CLKREQ_AUTO_EN |-> ##[0:3] !CLK_REQ;
  endproperty
  a_clkreq_off: assert property (p_clkreq_off)
    else $error("clock request kept in off");
  property p_offmode_seq;
    $rose(OFF_MODE) |-> !$past(I2C_SEQ_EN);
  endproperty
  a_offmode_seq: assert property (p_offmode_seq)
    else $error("off output with link sequencing");
  property p_adjust_rise;
    MONITOR_NEED [*4] |=> ADJUST_NEEDED;
  endproperty
  a_adjust_rise: assert property (p_adjust_rise)
    else $error("monitor need not passed on");
  property p_adjust_fall;
    !MONITOR_NEED [*4] |=> !ADJUST_NEEDED;
  endproperty
  a_adjust_fall: assert property (p_adjust_fall)
    else $error("monitor need stuck");
endmodule
bind voltage_scaling_standby_ctrl vscale_props #(.QTR(QTR)) u_props (
  .REF_CLK(REF_CLK),
  .RSTN(RSTN),
  .MONITOR_NEED(MONITOR_NEED),
  .CLKREQ_AUTO_EN(CLKREQ_AUTO_EN),
  .I2C_SEQ_EN(I2C_SEQ_EN),
  .SCL_OE(SCL_OE),
  .PROC_CLK_MHZ(PROC_CLK_MHZ),
  .ICON_CLK(ICON_CLK),
  .OPP_CUR(OPP_CUR),
  .BUSY(BUSY),
  .ADJUST_NEEDED(ADJUST_NEEDED),
  .CLK_REQ(CLK_REQ),
  .OFF_MODE(OFF_MODE),
  .IN_OFF(IN_OFF)
);

// *** test/pmic_model.sv ***
`timescale 1ns/1ps
`include "vscale_consts.vh"
// Regulator IC on the two-wire link, register writes only
module pmic_model (
  input wire scl,
  input wire sda,
  output logic sda_oe
);
  logic [7:0] sh;
  logic [7:0] reg_a;
  logic [5:0] tgt;
  logic [5:0] vout = 6'h00;
  logic conv_on = 1'b1;
  logic nack_mode = 1'b0;
  logic [15:0] wlog[$];
  int nbit = 9;
  int nbyte = 0;
  initial sda_oe = 1'b0;
  // Start condition restarts the frame
  always @(negedge sda) if (scl === 1'b1) begin
    nbit = 0;
    nbyte = 0;
  end
  // Bits taken MSB first on rising clock
  always @(posedge scl) if (nbit < 8) begin
    sh = {sh[6:0], sda};
    nbit++;
  end
  // Acknowledge slot and register updates
  always @(negedge scl) begin
    if (nbit == 8) begin
      nbit = 9;
      sda_oe <= !nack_mode && (nbyte > 0 || sh == {`PMIC_ADDR, 1'b0});
      if (nbyte == 1)
        reg_a = sh;
      if (nbyte == 2) begin
        wlog.push_back({reg_a, sh});
        if (reg_a == `PMIC_REG_TARGET)
          tgt = sh[5:0];
        if (reg_a == `PMIC_REG_GO && sh[7])
          vout = tgt;
        if (reg_a == `PMIC_REG_CTRL)
          conv_on = (sh == `PMIC_CTRL_ON);
      end
      nbyte++;
    end else if (nbit == 9) begin
      sda_oe <= 1'b0;
      nbit = 0;
    end
  end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "vscale_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  mismatches++; $display("wrong value at %0t got %0h", $time, (a)); end end
module tb_top;
  logic REF_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic OPP_REQ_VALID = 1'b0;
  logic [2:0] OPP_REQ = 3'h0;
  logic [9:0] PROC_CLK_REQ_MHZ = 10'h258;
  logic [10:0] ICON_CLK_REQ = 11'h7D0;
  logic MONITOR_NEED = 1'b0;
  logic SLEEP_REQ = 1'b0;
  logic OFF_REQ = 1'b0;
  logic RETENTION_REQ = 1'b0;
  logic WAKE_EVENT = 1'b0;
  logic CLKREQ_AUTO_EN = 1'b1;
  logic I2C_SEQ_EN = 1'b0;
  wire SCL_OE, SDA_OE, BUSY, NACK, ADJUST_NEEDED, CLK_REQ, OFF_MODE, IN_OFF;
  wire SCL_OUT, SDA_OUT, WAKE_SEEN;
  wire [9:0] PROC_CLK_MHZ;
  wire [10:0] ICON_CLK;
  wire [2:0] OPP_CUR;
  wire pm_oe;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  // Pulled-up open-drain link
  wire scl_w = !SCL_OE;
  wire sda_w = !(SDA_OE || pm_oe);
  always #10 REF_CLK = !REF_CLK;
  voltage_scaling_standby_ctrl #(.QTR(2), .SLOW_DIV(4)) u_dut (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .OPP_REQ_VALID(OPP_REQ_VALID),
    .OPP_REQ(OPP_REQ), .PROC_CLK_REQ_MHZ(PROC_CLK_REQ_MHZ),
    .ICON_CLK_REQ(ICON_CLK_REQ), .MONITOR_NEED(MONITOR_NEED),
    .SLEEP_REQ(SLEEP_REQ), .RETENTION_REQ(RETENTION_REQ), .OFF_REQ(OFF_REQ),
    .WAKE_EVENT(WAKE_EVENT), .CLKREQ_AUTO_EN(CLKREQ_AUTO_EN),
    .I2C_SEQ_EN(I2C_SEQ_EN), .SDA_IN(sda_w), .SCL_OUT(SCL_OUT),
    .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .PROC_CLK_MHZ(PROC_CLK_MHZ),
    .ICON_CLK(ICON_CLK), .OPP_CUR(OPP_CUR), .BUSY(BUSY), .NACK(NACK),
    .ADJUST_NEEDED(ADJUST_NEEDED), .CLK_REQ(CLK_REQ), .OFF_MODE(OFF_MODE),
    .IN_OFF(IN_OFF), .WAKE_SEEN(WAKE_SEEN));
  pmic_model u_pmic (.scl(scl_w), .sda(sda_w), .sda_oe(pm_oe));
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bounded wait on busy or off state
  task automatic wait_for(input bit sel, input logic v);
    int i;
    for (i = 0; i < 20000 && (sel ? IN_OFF : BUSY) !== v; i++)
      @(negedge REF_CLK);
    if (i == 20000) begin
      mismatches++;
      summarize();
    end
  endtask
  // Point change by request or sleep, then link and clock checks
  task automatic t_opp(input bit slp, input logic [2:0] p,
      input logic [9:0] mhz, input logic [9:0] clk, input logic [5:0] vc);
    n = u_pmic.wlog.size();
    PROC_CLK_REQ_MHZ = mhz;
    OPP_REQ = p;
    SLEEP_REQ = slp;
    OPP_REQ_VALID = !slp;
    wait_for(0, 1);
    wait_for(0, 0);
    SLEEP_REQ = 1'b0;
    OPP_REQ_VALID = 1'b0;
    repeat (2) @(negedge REF_CLK);
    `CHK(OPP_CUR, p)
    `CHK(u_pmic.wlog.size(), n + 2)
    `CHK(u_pmic.wlog[n], {`PMIC_REG_TARGET, 2'b00, vc})
    `CHK(u_pmic.wlog[n + 1], {`PMIC_REG_GO, `PMIC_GO_VAL})
    `CHK(u_pmic.vout, vc)
    `CHK(PROC_CLK_MHZ, clk)
    `CHK(NACK, 1'b0)
    `CHK({SCL_OUT, SDA_OUT}, 2'b00)
  endtask
  // Out-of-range point and a refused write
  task automatic t_refuse;
    n = u_pmic.wlog.size();
    OPP_REQ = 3'h5;
    OPP_REQ_VALID = 1'b1;
    repeat (20) @(negedge REF_CLK);
    OPP_REQ_VALID = 1'b0;
    `CHK(BUSY, 1'b0)
    `CHK(u_pmic.wlog.size(), n)
    @(negedge REF_CLK);
    u_pmic.nack_mode = 1'b1;
    OPP_REQ = 3'h2;
    OPP_REQ_VALID = 1'b1;
    wait_for(0, 1);
    wait_for(0, 0);
    OPP_REQ_VALID = 1'b0;
    u_pmic.nack_mode = 1'b0;
    `CHK(NACK, 1'b1)
    @(negedge REF_CLK);
  endtask
  // Off entry, quiet stay, wake exit
  task automatic t_off(input bit seq);
    I2C_SEQ_EN = seq;
    n = u_pmic.wlog.size();
    OFF_REQ = 1'b1;
    wait_for(1, 1);
    OFF_REQ = 1'b0;
    wait_for(0, 0);
    repeat (40) @(negedge REF_CLK);
    `CHK(IN_OFF, 1'b1)
    `CHK(WAKE_SEEN, 1'b0)
    `CHK(CLK_REQ, 1'b0)
    `CHK(OFF_MODE, !seq)
    if (seq) begin
      `CHK(u_pmic.wlog[n], {`PMIC_REG_CTRL, `PMIC_CTRL_OFF})
      `CHK(u_pmic.wlog[n + 1], {`PMIC_REG_CTRL, `PMIC_CTRL_ALL_OFF})
      `CHK(u_pmic.conv_on, 1'b0)
    end
    WAKE_EVENT = 1'b1;
    wait_for(1, 0);
    WAKE_EVENT = 1'b0;
    wait_for(0, 0);
    repeat (3) @(negedge REF_CLK);
    `CHK(CLK_REQ, 1'b1)
    `CHK(OFF_MODE, 1'b0)
    `CHK(u_pmic.wlog.size(), seq ? n + 4 : n)
    `CHK(u_pmic.conv_on, 1'b1)
  endtask
  // Clock request under retention, with and without auto drop
  task automatic t_clkreq;
    RETENTION_REQ = 1'b1;
    repeat (2) @(negedge REF_CLK);
    `CHK(CLK_REQ, 1'b0)
    CLKREQ_AUTO_EN = 1'b0;
    repeat (2) @(negedge REF_CLK);
    `CHK(CLK_REQ, 1'b1)
    RETENTION_REQ = 1'b0;
    CLKREQ_AUTO_EN = 1'b1;
    repeat (2) @(negedge REF_CLK);
    `CHK(CLK_REQ, 1'b1)
  endtask
  // Interconnect clock below the ceiling passes through
  task automatic t_icon;
    ICON_CLK_REQ = `ICON_CLK_1;
    repeat (3) @(negedge REF_CLK);
    `CHK(ICON_CLK, `ICON_CLK_1)
    ICON_CLK_REQ = 11'h7D0;
    repeat (3) @(negedge REF_CLK);
  endtask
  // Monitor flag passed to the host
  task automatic t_monitor;
    MONITOR_NEED = 1'b1;
    repeat (4) @(negedge REF_CLK);
    `CHK(ADJUST_NEEDED, 1'b1)
    MONITOR_NEED = 1'b0;
    repeat (4) @(negedge REF_CLK);
    `CHK(ADJUST_NEEDED, 1'b0)
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge REF_CLK);
    `CHK(OPP_CUR, `PROC_OPP_LOW)
    `CHK(PROC_CLK_MHZ, `PROC_MHZ_0)
    `CHK(ICON_CLK, `ICON_CLK_2)
    `CHK(CLK_REQ, 1'b1)
    RSTN = 1'b1;
    t_opp(0, 3'h4, 10'h258, `PROC_MHZ_4, `VCODE_4);
    t_opp(0, 3'h2, 10'h258, `PROC_MHZ_2, `VCODE_2);
    t_opp(0, 3'h1, 10'h064, 10'h064, `VCODE_1);
    t_opp(0, 3'h3, 10'h258, `PROC_MHZ_3, `VCODE_3);
    t_opp(1, 3'h0, 10'h258, `PROC_MHZ_0, `VCODE_0);
    t_refuse();
    t_opp(0, 3'h4, 10'h258, `PROC_MHZ_4, `VCODE_4);
    t_off(0);
    t_off(1);
    t_monitor();
    t_clkreq();
    t_icon();
    `CHK(ICON_CLK, `ICON_CLK_2)
    summarize();
  end
endmodule
